/* File: battery_level_alarm_flags.v */
// Threshold alarms, coulomb counter and charge readings of the gauge
`timescale 1ns/100ps
`include "gauge_alarm_map.vh"
module battery_level_alarm_flags #(
  parameter CAP_W = 16,
  parameter VOLT_W = 16,
  parameter [15:0] DEFAULT_FULL = 16'h03E8,
  parameter [15:0] DEFAULT_LOW_SET = 16'h0096,
  parameter [15:0] DEFAULT_SD_SET = 16'h0BB8,
  parameter [15:0] DEFAULT_SD_CLR = 16'h0C80,
  parameter [15:0] DEFAULT_FINAL_V = 16'h0B54
) (
  // Clock, reset, enable
  input wire clk,
  input wire sys_rst,
  input wire clk_en,
  // Wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [5:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // Measurement front end
  input wire meas_valid,
  input wire [VOLT_W-1:0] cell_voltage,
  input wire signed [15:0] sense_charge,
  input wire [CAP_W-1:0] load_loss,
  // Pins and interrupts
  output reg low_battery_pin,
  output reg soc_int_pulse,
  output wire irq
);

  reg ctrl_reg;
  reg [CAP_W-1:0] low_set_reg;
  reg [VOLT_W-1:0] sd_set_reg;
  reg [VOLT_W-1:0] sd_clr_reg;
  reg [VOLT_W-1:0] final_v_reg;
  reg [CAP_W-1:0] uncomp_rem_reg;
  reg [CAP_W-1:0] uncomp_full_reg;
  reg [CAP_W-1:0] remain_reg;
  reg [CAP_W-1:0] full_reg;
  reg [7:0] soc_reg;
  reg [VOLT_W-1:0] volt_reg;
  reg low_charge_flag;
  reg shutdown_voltage_flag;
  reg [`IRQ_BITS-1:0] irq_stat_reg;
  reg [`IRQ_BITS-1:0] irq_mask_reg;

  // Saturating capacity subtraction
  function [CAP_W-1:0] sat_sub;
    input [CAP_W-1:0] a;
    input [CAP_W-1:0] b;
    begin
      sat_sub = (a > b) ? a - b : {CAP_W{1'b0}};
    end
  endfunction

  // Charge accumulation, clamped to full and zero
  reg [CAP_W:0] acc_sum;
  reg [CAP_W-1:0] acc_next;
  always @* begin
    acc_sum = {1'b0, uncomp_rem_reg} + {{(CAP_W-15){sense_charge[15]}},
      sense_charge[14:0]};
    if (sense_charge[15] && (acc_sum[CAP_W] == 1'b0))
      acc_next = {CAP_W{1'b0}};
    else if (!sense_charge[15] && (acc_sum[CAP_W] ||
             acc_sum[CAP_W-1:0] > uncomp_full_reg))
      acc_next = uncomp_full_reg;
    else
      acc_next = acc_sum[CAP_W-1:0];
  end

  wire [CAP_W-1:0] remain_next = sat_sub(acc_next, load_loss);
  wire [CAP_W-1:0] full_next = sat_sub(uncomp_full_reg, load_loss);
  wire low_next = (remain_next < low_set_reg) ? 1'b1 :
    (remain_next > low_set_reg) ? 1'b0 : low_charge_flag;
  wire sd_set_hit = cell_voltage < sd_set_reg;
  wire sd_clr_hit = shutdown_voltage_flag &&
    (cell_voltage > sd_clr_reg);
  wire sd_rise = meas_valid && !shutdown_voltage_flag && sd_set_hit;
  wire sd_fall = meas_valid && sd_clr_hit && !sd_set_hit;
  wire low_rise = meas_valid && low_next && !low_charge_flag;

  // State of charge in percent
  wire [CAP_W+6:0] pct_num = remain_next * 7'h64;
  wire [CAP_W+6:0] pct_quot = pct_num / full_next;
  wire [7:0] soc_calc = (full_next == {CAP_W{1'b0}}) ? 8'h00 :
    pct_quot[7:0];

  // Writes land at the edge where the master sees ack high
  wire wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire wb_wr = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0];
  wire [`IRQ_BITS-1:0] ev = {low_rise, sd_fall, sd_rise};
  wire [`IRQ_BITS-1:0] w1c = (wb_wr && wb_adr_i == `ADR_IRQ_STAT) ?
    wb_dat_i[`IRQ_BITS-1:0] : {`IRQ_BITS{1'b0}};

  always @(posedge clk) begin
    if (sys_rst) begin
      ctrl_reg <= 1'b0;
      low_set_reg <= DEFAULT_LOW_SET[CAP_W-1:0];
      sd_set_reg <= DEFAULT_SD_SET[VOLT_W-1:0];
      sd_clr_reg <= DEFAULT_SD_CLR[VOLT_W-1:0];
      final_v_reg <= DEFAULT_FINAL_V[VOLT_W-1:0];
      uncomp_rem_reg <= DEFAULT_FULL[CAP_W-1:0];
      uncomp_full_reg <= DEFAULT_FULL[CAP_W-1:0];
      remain_reg <= DEFAULT_FULL[CAP_W-1:0];
      full_reg <= DEFAULT_FULL[CAP_W-1:0];
      soc_reg <= `FULL_SOC;
      volt_reg <= {VOLT_W{1'b0}};
      low_charge_flag <= 1'b0;
      shutdown_voltage_flag <= 1'b0;
      irq_stat_reg <= {`IRQ_BITS{1'b0}};
      irq_mask_reg <= {`IRQ_BITS{1'b0}};
      low_battery_pin <= 1'b0;
      soc_int_pulse <= 1'b0;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else if (clk_en) begin
      wb_ack_o <= wb_req;
      soc_int_pulse <= sd_rise || sd_fall;
      low_battery_pin <= ctrl_reg &&
        low_charge_flag;
      irq_stat_reg <= (irq_stat_reg & ~w1c) | ev;
      if (meas_valid) begin
        volt_reg <= cell_voltage;
        uncomp_rem_reg <= acc_next;
        remain_reg <= remain_next;
        full_reg <= full_next;
        low_charge_flag <= low_next;
        if (sd_rise)
          shutdown_voltage_flag <= 1'b1;
        else if (sd_fall)
          shutdown_voltage_flag <= 1'b0;
        if (cell_voltage <= final_v_reg)
          soc_reg <= 8'h00;
        else
          soc_reg <= soc_calc;
      end
      if (wb_wr) begin
        case (wb_adr_i)
          `ADR_CTRL: ctrl_reg <= wb_dat_i[`CTRL_LOW_PIN_EN];
          `ADR_LOW_SET: low_set_reg <= wb_dat_i[CAP_W-1:0];
          `ADR_SD_SET: sd_set_reg <= wb_dat_i[VOLT_W-1:0];
          `ADR_SD_CLR: sd_clr_reg <= wb_dat_i[VOLT_W-1:0];
          `ADR_FINAL_V: final_v_reg <= wb_dat_i[VOLT_W-1:0];
          `ADR_UNC_FULL: uncomp_full_reg <= wb_dat_i[CAP_W-1:0];
          `ADR_IRQ_MASK: irq_mask_reg <= wb_dat_i[`IRQ_BITS-1:0];
          default: ;
        endcase
      end
      if (wb_req) begin
        case (wb_adr_i)
          `ADR_CTRL: wb_dat_o <= {31'h0, ctrl_reg};
          `ADR_LOW_SET: wb_dat_o <= {{(32-CAP_W){1'b0}}, low_set_reg};
          `ADR_SD_SET: wb_dat_o <= {{(32-VOLT_W){1'b0}}, sd_set_reg};
          `ADR_SD_CLR: wb_dat_o <= {{(32-VOLT_W){1'b0}}, sd_clr_reg};
          `ADR_FINAL_V: wb_dat_o <= {{(32-VOLT_W){1'b0}}, final_v_reg};
          `ADR_REMAIN: wb_dat_o <= {{(32-CAP_W){1'b0}}, remain_reg};
          `ADR_FULL: wb_dat_o <= {{(32-CAP_W){1'b0}}, full_reg};
          `ADR_UNC_REM: wb_dat_o <= {{(32-CAP_W){1'b0}}, uncomp_rem_reg};
          `ADR_UNC_FULL: wb_dat_o <= {{(32-CAP_W){1'b0}}, uncomp_full_reg};
          `ADR_SOC: wb_dat_o <= {24'h000000, soc_reg};
          `ADR_FLAGS: wb_dat_o <= {30'h0, shutdown_voltage_flag,
            low_charge_flag};
          `ADR_IRQ_STAT: wb_dat_o <= {29'h0, irq_stat_reg};
          `ADR_IRQ_MASK: wb_dat_o <= {29'h0, irq_mask_reg};
          `ADR_VOLT: wb_dat_o <= {{(32-VOLT_W){1'b0}}, volt_reg};
          default: wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign irq = |(irq_stat_reg & irq_mask_reg);

endmodule // battery_level_alarm_flags

/* File: gauge_alarm_map.vh */
// Register map, field positions and reset values of the gauge alarm block
`ifndef GAUGE_ALARM_MAP_VH
`define GAUGE_ALARM_MAP_VH
`define ADR_CTRL 6'h00
`define ADR_LOW_SET 6'h04
`define ADR_SD_SET 6'h08
`define ADR_SD_CLR 6'h0C
`define ADR_FINAL_V 6'h10
`define ADR_REMAIN 6'h14
`define ADR_FULL 6'h18
`define ADR_UNC_REM 6'h1C
`define ADR_UNC_FULL 6'h20
`define ADR_SOC 6'h24
`define ADR_FLAGS 6'h28
`define ADR_IRQ_STAT 6'h2C
`define ADR_IRQ_MASK 6'h30
`define ADR_VOLT 6'h34
`define CTRL_LOW_PIN_EN 0
`define FLAG_LOW_CHARGE 0
`define FLAG_SHUTDOWN 1
`define IRQ_SD_SET 0
`define IRQ_SD_CLR 1
`define IRQ_LOW_CHG 2
`define IRQ_BITS 3
`define FULL_SOC 8'h64
`endif

/* File: host_model.sv */
// Host model: classic Wishbone master reading and writing the gauge registers
`timescale 1ns/100ps
module host_model (
  // Bus
  input wire clk,
  input wire ack,
  input wire [31:0] rd,
  output logic cyc = 1'b0,
  output logic we = 1'b0,
  output logic [5:0] adr = 6'h00,
  output logic [31:0] wd = 32'h0
);
  task automatic acc(input logic w, input logic [5:0] a,
    input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wd <= d;
    do @(posedge clk); while (ack !== 1'b1);
    q = rd;
    cyc <= 1'b0;
  endtask
endmodule // host_model

/* File: alarm_chk.sv */
// Checker of bus, interrupt and pin timing
`timescale 1ns/100ps
module alarm_chk #(
  parameter [15:0] SD_SET = 16'h0BB8,
  parameter [15:0] SD_CLR = 16'h0C80
) (
  input wire clk, sys_rst, clk_en, wb_cyc_i, wb_stb_i, wb_we_i,
  input wire [5:0] wb_adr_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o, meas_valid,
  input wire [15:0] cell_voltage,
  input wire low_battery_pin, soc_int_pulse, irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence req;
    wb_cyc_i && wb_stb_i && !wb_ack_o && clk_en;
  endsequence
  sequence band;
    meas_valid && cell_voltage >= SD_SET && cell_voltage <= SD_CLR;
  endsequence
  ack_resp_a: assert property (req |=> wb_ack_o) else $error("no ack");
  ack_pulse_a: assert property (wb_ack_o && clk_en |=> !wb_ack_o)
    else $error("long ack");
  ack_cause_a: assert property ($rose(wb_ack_o) |-> $past(wb_stb_i))
    else $error("stray ack");
  rd_unmap_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o &&
    clk_en && !wb_we_i && wb_adr_i > 6'h34
    |=> wb_dat_o == 32'h0) else $error("unmapped data");
  band_quiet_a: assert property (band |=> !soc_int_pulse)
    else $error("pulse in band");
  pulse_cause_a: assert property (
    soc_int_pulse |-> $past(meas_valid)) else $error("stray pulse");
  irq_cause_a: assert property ($changed(irq) |->
    $past(meas_valid) || $past(wb_ack_o)) else $error("stray irq");
  pin_cause_a: assert property ($changed(low_battery_pin) |->
    $past(meas_valid, 2) || $past(wb_ack_o, 2)) else $error("stray pin");
endmodule // alarm_chk
bind battery_level_alarm_flags alarm_chk #(.SD_SET(DEFAULT_SD_SET),
  .SD_CLR(DEFAULT_SD_CLR)) i_chk (.*);

/* File: tb.sv */
// Testbench of the battery level alarm block
`timescale 1ns/100ps
`include "gauge_alarm_map.vh"
module tb;
  logic clk = 1'b0, sys_rst = 1'b1, mv = 1'b0, p, pin, pls, irq, ack;
  logic cyc, we;
  logic [15:0] v = 16'h0D00, loss = 16'h0;
  logic signed [15:0] chg = 16'sh0;
  logic [5:0] adr;
  logic [31:0] wd, rd, q;
  int miscompares = 0, samples_checked = 0;
  always #10 clk = ~clk;
  host_model i_host (.clk(clk), .ack(ack), .rd(rd), .cyc(cyc), .we(we),
    .adr(adr), .wd(wd));
  battery_level_alarm_flags i_dut (.clk(clk), .sys_rst(sys_rst),
    .clk_en(1'b1), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wd), .wb_dat_o(rd),
    .wb_ack_o(ack), .meas_valid(mv), .cell_voltage(v),
    .sense_charge(chg), .load_loss(loss), .low_battery_pin(pin),
    .soc_int_pulse(pls), .irq(irq));
  task automatic cmp(input logic [31:0] g, e);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic rc(input logic [5:0] a, input logic [31:0] e);
    i_host.acc(1'b0, a, 32'h0, q);
    cmp(q, e);
  endtask
  // One update; p tells whether the interrupt pulse followed
  task automatic m(input logic [15:0] vv, ll, c);
    @(posedge clk);
    mv <= 1'b1;
    v <= vv;
    loss <= ll;
    chg <= c;
    @(posedge clk);
    mv <= 1'b0;
    #1 p = pls;
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk);
    miscompares++;
    end_sim;
  end
  task automatic t_reset;
    rc(`ADR_FLAGS, 32'h0);
    rc(`ADR_SOC, 32'h64);
    rc(6'h3C, 32'h0);
    $display("reset test done");
  endtask
  task automatic t_shutdown;
    i_host.acc(1'b1, `ADR_IRQ_MASK, 32'h3, q);
    m(16'h0B54, 16'h0, 16'h0);
    cmp(p, 1'b1);
    cmp(irq, 1'b1);
    rc(`ADR_FLAGS, 32'h2);
    rc(`ADR_SOC, 32'h0);
    m(16'h0C80, 16'h0, 16'h0);
    cmp(p, 1'b0);
    i_host.acc(1'b1, `ADR_IRQ_STAT, 32'h1, q);
    #1 cmp(irq, 1'b0);
    m(16'h0C81, 16'h0, 16'h0);
    cmp(p, 1'b1);
    rc(`ADR_FLAGS, 32'h0);
    rc(`ADR_IRQ_STAT, 32'h2);
    $display("shutdown test done");
  endtask
  task automatic t_low;
    i_host.acc(1'b1, `ADR_CTRL, 32'h1, q);
    m(16'h0D00, 16'h0360, 16'h0);
    rc(`ADR_FLAGS, 32'h1);
    cmp(pin, 1'b1);
    i_host.acc(1'b1, `ADR_CTRL, 32'h0, q);
    repeat (2) @(posedge clk);
    cmp(pin, 1'b0);
    m(16'h0D00, 16'h0352, 16'h0);
    rc(`ADR_FLAGS, 32'h1);
    m(16'h0D00, 16'h0351, 16'h0);
    rc(`ADR_FLAGS, 32'h0);
    $display("low charge test done");
  endtask
  task automatic t_count;
    m(16'h0D00, 16'h0064, -16'sd100);
    rc(`ADR_UNC_REM, 32'h384);
    rc(`ADR_REMAIN, 32'h320);
    rc(`ADR_FULL, 32'h384);
    rc(`ADR_UNC_FULL, 32'h3E8);
    $display("count test done");
  endtask
  initial begin
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset;
    t_shutdown;
    t_low;
    t_count;
    end_sim;
  end
endmodule // tb
